/* File: rtl/mesw_core.sv */
// The AHB-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - a test that ends with no fault reports an all-zero status word.
// - the status word is 16 bits and each fault owns one bit, so faults accumulate.
// - voltage over-range sets bit 0 and current over-range bit 1, together giving 3.
// - a ramp abandoned for too heavy a load sets bit 2.
// - a measurement not settled in time sets bit 4 even on a passing result.
// - a stimulus that cannot be trimmed to level sets bit 5.
// - current not decaying in time after ramp-down sets bit 6.
// - a hi-pot current above the programmed limit sets bit 8.
// - a fixture voltage sense that fails to clear in time sets bit 9.
// - an interrupt ending the test sets bit 10 and puts its reason in bits 12 to 15.
// - reason 1 is a safety interlock break and 3 a flashover or over-current trip.
// - reason 4 is a remote stop request.
// - reason 5 is an output voltage above 8kV.
// - reason 7 is over-temperature and 8 a peripherals port trip.
// - the word is shown as four hex digits; a reason sub-code appears only on self-test fail.
// - every test result handed to the host carries the four-digit word at its end.
module mesw_core
  import mesw_pkg::*;
#(
  parameter int RESULT_W = 16
) (
  input wire logic mclk, // system clock, 200 MHz
  input wire logic reset, // async reset, active high
  input wire logic [31:0] haddr, // ahb address
  input wire logic [1:0] htrans, // ahb transfer type
  input wire logic hwrite, // ahb write
  input wire logic [2:0] hsize, // ahb size
  input wire logic [31:0] hwdata, // ahb write data
  input wire logic hsel, // ahb select
  input wire logic hready, // ahb bus ready
  output logic [31:0] hrdata, // ahb read data
  output logic hreadyout, // ahb slave ready
  output logic hresp, // ahb response, always okay
  input wire logic test_start, // pulse: a test begins
  input wire logic test_end, // pulse: a test ends, result valid
  input wire logic [RESULT_W-1:0] test_result, // measured value at test end
  input wire logic [NUM_FAULTS-1:0] fault_in, // fault pulses, see fault_pos
  input wire logic intr_req, // pulse: interrupt terminates the test
  input wire logic [3:0] intr_reason, // reason code with intr_req
  input wire logic selftest_fail, // level: self-test failed
  input wire logic [7:0] selftest_code, // self-test sub-code
  output logic [RESULT_W+15:0] host_record, // result then status word
  output logic host_valid, // pulse: host_record valid
  output logic [15:0] disp_word, // four hex digits shown
  output logic [7:0] disp_sub, // sub-code shown, zero unless self-test fail
  output logic disp_sub_en, // sub-code visible
  output logic irq // level interrupt
);
  // fault_in index to word bit mapping
  localparam int FAULT_POS [NUM_FAULTS] = '{BIT_VOVR, BIT_IOVR, BIT_RAMP, BIT_SETTLE,
                                            BIT_TRIM, BIT_DECAY, BIT_ILIM, BIT_VPRES};
  // bits 3, 7 and 11 carry no fault and must stay clear
  localparam logic [15:0] WORD_USED = 16'hF777;

  test_state_t state_reg;
  logic [15:0] word_reg;
  logic [15:0] word_next;
  logic [15:0] set_bits;
  logic intr_seen_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [IRQ_W-1:0] irq_set;
  logic ctrl_clr_reg;
  logic [15:0] count_reg;
  logic [7:0] dp_addr_reg;
  logic dp_wr_reg;
  logic dp_rd_reg;
  logic [31:0] rdata_next;

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_bits
      if (gi == BIT_VOVR) begin : g_f0
        assign set_bits[gi] = fault_in[0];
      end else if (gi == BIT_IOVR) begin : g_f1
        assign set_bits[gi] = fault_in[1];
      end else if (gi == BIT_RAMP) begin : g_f2
        assign set_bits[gi] = fault_in[2];
      end else if (gi == BIT_SETTLE) begin : g_f3
        assign set_bits[gi] = fault_in[3];
      end else if (gi == BIT_TRIM) begin : g_f4
        assign set_bits[gi] = fault_in[4];
      end else if (gi == BIT_DECAY) begin : g_f5
        assign set_bits[gi] = fault_in[5];
      end else if (gi == BIT_ILIM) begin : g_f6
        assign set_bits[gi] = fault_in[6];
      end else if (gi == BIT_VPRES) begin : g_f7
        assign set_bits[gi] = fault_in[7];
      end else begin : g_none
        assign set_bits[gi] = 1'b0;
      end
    end
  endgenerate

  // only the first interrupt of a test names the reason
  always_comb begin
    word_next = word_reg | set_bits;
    if (intr_req && !intr_seen_reg) begin
      word_next[BIT_INTR] = 1'b1;
      word_next[REASON_LSB +: 4] = intr_reason;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      word_reg <= WORD_CLEAR;
      intr_seen_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE, ST_DONE: begin
          if (test_start) begin
            state_reg <= ST_RUN;
            word_reg <= WORD_CLEAR;
            intr_seen_reg <= 1'b0;
          end else if (ctrl_clr_reg) begin
            word_reg <= WORD_CLEAR;
          end
        end
        ST_RUN: begin
          word_reg <= word_next;
          if (intr_req) begin
            intr_seen_reg <= 1'b1;
          end
          if (test_end || intr_req) begin
            state_reg <= ST_DONE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // host record built from the word as it stands after the final cycle
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      host_record <= '0;
      host_valid <= 1'b0;
      count_reg <= 16'h0000;
    end else begin
      host_valid <= 1'b0;
      if (state_reg == ST_RUN && (test_end || intr_req)) begin
        host_record <= {test_result, word_next};
        host_valid <= 1'b1;
        count_reg <= count_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      disp_word <= WORD_CLEAR;
      disp_sub <= 8'h00;
      disp_sub_en <= 1'b0;
    end else begin
      disp_word <= word_reg;
      disp_sub_en <= selftest_fail;
      disp_sub <= selftest_fail ? selftest_code : 8'h00;
    end
  end

  assign irq_set[IRQ_DONE] = state_reg == ST_RUN && (test_end || intr_req);
  assign irq_set[IRQ_FAULT] = state_reg == ST_RUN && (test_end || intr_req)
                              && word_next != WORD_CLEAR;
  assign irq_set[IRQ_TERM] = state_reg == ST_RUN && intr_req && !intr_seen_reg;

  // ahb data phase decode
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      dp_addr_reg <= 8'h00;
      dp_wr_reg <= 1'b0;
      dp_rd_reg <= 1'b0;
    end else if (hready) begin
      dp_addr_reg <= haddr[7:0];
      dp_wr_reg <= hsel && htrans[1] && hwrite && hsize == HSIZE_WORD;
      dp_rd_reg <= hsel && htrans[1] && !hwrite;
    end
  end

  // set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      ctrl_clr_reg <= 1'b0;
    end else begin
      ctrl_clr_reg <= 1'b0;
      if (dp_wr_reg && dp_addr_reg == OFS_IRQ_STAT) begin
        irq_stat_reg <= (irq_stat_reg & ~hwdata[IRQ_W-1:0]) | irq_set;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_set;
      end
      if (dp_wr_reg && dp_addr_reg == OFS_IRQ_MASK) begin
        irq_mask_reg <= hwdata[IRQ_W-1:0];
      end
      if (dp_wr_reg && dp_addr_reg == OFS_CTRL) begin
        ctrl_clr_reg <= hwdata[0];
      end
    end
  end

  always_comb begin
    rdata_next = 32'h0000_0000;
    case (haddr[7:0])
      OFS_WORD: rdata_next = {16'h0000, word_reg};
      OFS_RESULT: rdata_next = host_record[31:0];
      OFS_IRQ_STAT: rdata_next = {29'h0, irq_stat_reg};
      OFS_IRQ_MASK: rdata_next = {29'h0, irq_mask_reg};
      OFS_COUNT: rdata_next = {14'h0, state_reg, count_reg};
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      irq <= 1'b0;
    end else begin
      if (hready && hsel && htrans[1] && !hwrite) begin
        hrdata <= rdata_next;
      end
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  clean_run_a: assert property (@(posedge mclk) disable iff (reset)
    state_reg == ST_RUN && fault_in == '0 && !intr_req && word_reg == WORD_CLEAR
    |=> word_reg == WORD_CLEAR)
    else $error("word changed with no fault");
  clear_start_a: assert property (@(posedge mclk) disable iff (reset)
    state_reg != ST_RUN && test_start |=> word_reg == WORD_CLEAR && state_reg == ST_RUN)
    else $error("word not cleared at test start");
  vovr_bit_a: assert property (@(posedge mclk) disable iff (reset)
    state_reg == ST_RUN && fault_in[0] |=> word_reg[BIT_VOVR])
    else $error("voltage over-range bit not set");
  accum_a: assert property (@(posedge mclk) disable iff (reset)
    state_reg == ST_RUN && !test_start |=> (word_reg & $past(word_reg)) == $past(word_reg))
    else $error("fault bit lost during test");
  settle_bit_a: assert property (@(posedge mclk) disable iff (reset)
    state_reg == ST_RUN && fault_in[3] |=> word_reg[BIT_SETTLE])
    else $error("settle bit not set");
  intr_code_a: assert property (@(posedge mclk) disable iff (reset)
    state_reg == ST_RUN && intr_req && !intr_seen_reg
    |=> word_reg[BIT_INTR] && word_reg[15:12] == $past(intr_reason))
    else $error("interrupt code not stored");
  record_a: assert property (@(posedge mclk) disable iff (reset)
    host_valid |-> host_record[15:0] == word_reg)
    else $error("host record word mismatch");
  disp_sub_a: assert property (@(posedge mclk) disable iff (reset)
    !selftest_fail |=> !disp_sub_en ##0 disp_sub == 8'h00)
    else $error("sub-code shown without self-test fail");
  ilim_bit_a: assert property (@(posedge mclk) disable iff (reset)
    state_reg == ST_RUN && fault_in[6] |=> word_reg[BIT_ILIM])
    else $error("current limit bit not set");

  // word bits rebuilt from the fault map, kept apart from set_bits
  logic [15:0] fault_map;
  always_comb begin
    fault_map = WORD_CLEAR;
    for (int k = 0; k < NUM_FAULTS; k++) begin
      fault_map[FAULT_POS[k]] = fault_in[k];
    end
  end

  genvar fi;
  generate
    for (fi = 0; fi < NUM_FAULTS; fi++) begin : g_fault_chk
      fault_bit_a: assert property (@(posedge mclk) disable iff (reset)
        state_reg == ST_RUN && fault_in[fi] |=> word_reg[FAULT_POS[fi]])
        else $error("fault bit not set");
    end
  endgenerate

  own_bit_a: assert property (@(posedge mclk) disable iff (reset)
    state_reg == ST_RUN && !intr_req
    |=> word_reg == ($past(word_reg) | $past(fault_map)))
    else $error("fault set a bit it does not own");
  dual_ovr_a: assert property (@(posedge mclk) disable iff (reset)
    state_reg == ST_RUN && fault_in[BIT_IOVR:BIT_VOVR] == 2'b11
    |=> word_reg[BIT_IOVR:BIT_VOVR] == 2'b11)
    else $error("combined over-range not three");
  spare_zero_a: assert property (@(posedge mclk) disable iff (reset)
    (word_reg & ~WORD_USED) == WORD_CLEAR)
    else $error("unused word bit set");
  intr_only_a: assert property (@(posedge mclk) disable iff (reset)
    state_reg == ST_RUN && !intr_req && !word_reg[BIT_INTR] |=> !word_reg[BIT_INTR])
    else $error("interrupt bit set with no interrupt");

  // record and display
  end_done_a: assert property (@(posedge mclk) disable iff (reset)
    state_reg == ST_RUN && (test_end || intr_req) |=> state_reg == ST_DONE && host_valid)
    else $error("test end gave no host record");
  record_res_a: assert property (@(posedge mclk) disable iff (reset)
    host_valid |-> host_record[RESULT_W+15:16] == $past(test_result))
    else $error("host record result mismatch");
  host_pulse_a: assert property (@(posedge mclk) disable iff (reset)
    host_valid |=> !host_valid)
    else $error("host record strobe longer than one cycle");
  no_test_rec_a: assert property (@(posedge mclk) disable iff (reset)
    state_reg == ST_IDLE |-> !host_valid)
    else $error("host record with no test run");
  done_hold_a: assert property (@(posedge mclk) disable iff (reset)
    state_reg == ST_DONE && !test_start && !ctrl_clr_reg |=> $stable(word_reg))
    else $error("reported word changed after the test");
  disp_word_a: assert property (@(posedge mclk) disable iff (reset)
    disp_word == $past(word_reg))
    else $error("display word does not follow the status word");
  disp_sub_on_a: assert property (@(posedge mclk) disable iff (reset)
    selftest_fail |=> disp_sub_en && disp_sub == $past(selftest_code))
    else $error("sub-code missing on self-test fail");

  // bus and interrupt logic; a stalled data phase would hang software polling
  bus_ready_a: assert property (@(posedge mclk) disable iff (reset)
    (dp_rd_reg || dp_wr_reg) |-> hreadyout && !hresp)
    else $error("data phase stalled or errored");
  ctrl_clear_a: assert property (@(posedge mclk) disable iff (reset)
    state_reg != ST_RUN && !test_start && ctrl_clr_reg |=> word_reg == WORD_CLEAR)
    else $error("control clear did not empty the word");
  mask_irq_a: assert property (@(posedge mclk) disable iff (reset)
    (irq_stat_reg & irq_mask_reg) == '0 |=> !irq)
    else $error("interrupt raised while all events masked");
  genvar qi;
  generate
    for (qi = 0; qi < IRQ_W; qi++) begin : g_irq_chk
      stat_set_a: assert property (@(posedge mclk) disable iff (reset)
        irq_set[qi] |=> irq_stat_reg[qi])
        else $error("status event lost to a clear");
    end
  endgenerate

  clean_test_c: cover property (@(posedge mclk) disable iff (reset)
    host_valid && host_record[15:0] == WORD_CLEAR);
  dual_ovr_c: cover property (@(posedge mclk) disable iff (reset)
    host_valid && host_record[15:0] == 16'h0003);
  stop_c: cover property (@(posedge mclk) disable iff (reset)
    host_valid && host_record[15:12] == RSN_STOP);
  intr_end_c: cover property (@(posedge mclk) disable iff (reset)
    host_valid && host_record[BIT_INTR]);
  selftest_c: cover property (@(posedge mclk) disable iff (reset)
    disp_sub_en && disp_sub != 8'h00);
endmodule : mesw_core

/* File: common/mesw_pkg.sv */
package mesw_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_WORD = 8'h04;
  localparam logic [7:0] OFS_RESULT = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFS_COUNT = 8'h14;
  // error word bit positions
  localparam int BIT_VOVR = 0;
  localparam int BIT_IOVR = 1;
  localparam int BIT_RAMP = 2;
  localparam int BIT_SETTLE = 4;
  localparam int BIT_TRIM = 5;
  localparam int BIT_DECAY = 6;
  localparam int BIT_ILIM = 8;
  localparam int BIT_VPRES = 9;
  localparam int BIT_INTR = 10;
  localparam int REASON_LSB = 12;
  localparam int NUM_FAULTS = 8;
  localparam logic [15:0] WORD_CLEAR = 16'h0000;
  // interrupt reason codes
  localparam logic [3:0] RSN_NONE = 4'h0;
  localparam logic [3:0] RSN_INTERLOCK = 4'h1;
  localparam logic [3:0] RSN_HV_TRIP = 4'h3;
  localparam logic [3:0] RSN_STOP = 4'h4;
  localparam logic [3:0] RSN_OVER_8KV = 4'h5;
  localparam logic [3:0] RSN_OVERTEMP = 4'h7;
  localparam logic [3:0] RSN_AUX_TRIP = 4'h8;
  // irq status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAULT = 1;
  localparam int IRQ_TERM = 2;
  localparam int IRQ_W = 3;
  // ahb encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] HSIZE_WORD = 3'b010;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_DONE = 2'b11
  } test_state_t;
endpackage : mesw_pkg

/* File: tb/seq_model.sv */
`timescale 1ns/1ps
module seq_model (
  input wire logic mclk, // system clock
  output logic test_start, // a test begins
  output logic test_end, // a test ends
  output logic [15:0] test_result, // measured value
  output logic [7:0] fault_in, // fault pulses
  output logic intr_req, // interrupt ends the test
  output logic [3:0] intr_reason, // interrupt reason code
  output logic selftest_fail, // self-test failed
  output logic [7:0] selftest_code // self-test sub-code
);
  initial begin
    {test_start, test_end, intr_req, selftest_fail} = 4'h0;
    {test_result, fault_in, intr_reason, selftest_code} = 36'h0;
  end
  task automatic run(input logic [7:0] f, input logic ie, input logic [3:0] rsn,
      input logic [15:0] res);
    @(posedge mclk);
    test_start <= 1'b1;
    @(posedge mclk);
    test_start <= 1'b0;
    fault_in <= f;
    @(posedge mclk);
    fault_in <= 8'h00;
    intr_req <= ie;
    test_end <= ~ie;
    intr_reason <= rsn;
    test_result <= res;
    @(posedge mclk);
    {intr_req, test_end} <= 2'b00;
    // released lines carry junk so a stale sample cannot pass
    intr_reason <= ~rsn;
    test_result <= ~res;
  endtask : run
  task automatic self_test(input logic fl, input logic [7:0] code);
    @(posedge mclk);
    selftest_fail <= fl;
    selftest_code <= code;
  endtask : self_test
endmodule : seq_model

/* File: tb/measurement_error_status_word_test.sv */
`timescale 1ns/1ps
module measurement_error_status_word_test;
  import mesw_pkg::*;
  logic mclk, reset, hwrite, hreadyout, hresp, host_valid, disp_sub_en, irq;
  logic test_start, test_end, intr_req, selftest_fail;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, host_record, rd, rec;
  logic [15:0] test_result, disp_word;
  logic [7:0] fault_in, selftest_code, disp_sub;
  logic [3:0] intr_reason;
  int error_cnt = 0;
  int samples_checked = 0;
  int recs = 0;
  mesw_core dut (.mclk, .reset, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hsel(1'b1),
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .test_start, .test_end, .test_result,
    .fault_in, .intr_req, .intr_reason, .selftest_fail, .selftest_code, .host_record,
    .host_valid, .disp_word, .disp_sub, .disp_sub_en, .irq);
  seq_model seq (.mclk, .test_start, .test_end, .test_result, .fault_in, .intr_req,
    .intr_reason, .selftest_fail, .selftest_code);
  always @(posedge mclk) if (host_valid === 1'b1) begin
    rec <= host_record;
    recs <= recs + 1;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 16);
    if (hreadyout !== 1'b1) begin
      error_cnt++;
      print_verdict();
    end
  endtask : wait_ready
  task automatic ahb(input logic [7:0] a, input logic wr, input logic [31:0] wd);
    @(posedge mclk);
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask : ahb
  task automatic get_rec(input logic [7:0] f, input logic ie, input logic [3:0] rsn);
    int r0;
    int n;
    r0 = recs;
    seq.run(f, ie, rsn, 16'hA5C3);
    for (n = 0; n < 8 && recs == r0; n++) @(negedge mclk);
    if (recs == r0) begin
      error_cnt++;
      print_verdict();
    end
  endtask : get_rec
  task automatic sc_faults();
    int pos[8] = '{BIT_VOVR, BIT_IOVR, BIT_RAMP, BIT_SETTLE, BIT_TRIM, BIT_DECAY,
      BIT_ILIM, BIT_VPRES};
    logic [15:0] w[8] = '{16'h1, 16'h2, 16'h4, 16'h10, 16'h20, 16'h40, 16'h100, 16'h200};
    for (int i = 0; i < 8; i++) begin
      get_rec(8'h01 << i, 1'b0, 4'h0);
      check($sformatf("fault %0d", pos[i]), rec, {16'hA5C3, w[i]});
    end
    get_rec(8'h03, 1'b0, 4'h0);
    check("both over-range", rec, 32'hA5C30003);
    get_rec(8'hFF, 1'b0, 4'h0);
    check("all faults", rec, 32'hA5C30377);
    ahb(OFS_WORD, 1'b0, 32'h0);
    check("word reg", rd, 32'h377);
    check("disp word", {16'h0, disp_word}, 32'h377);
  endtask : sc_faults
  task automatic sc_intr();
    logic [3:0] code[6] = '{4'h1, 4'h3, 4'h4, 4'h5, 4'h7, 4'h8};
    for (int i = 0; i < 6; i++) begin
      get_rec(8'h01, 1'b1, code[i]);
      check("interrupt", rec, {16'hA5C3, code[i], 12'h401});
    end
  endtask : sc_intr
  task automatic sc_clean();
    get_rec(8'h00, 1'b0, 4'h0);
    check("clean", rec, 32'hA5C30000);
  endtask : sc_clean
  task automatic sc_selftest();
    seq.self_test(1'b1, 8'h2A);
    repeat (2) @(negedge mclk);
    check("sub shown", {23'h0, disp_sub_en, disp_sub}, 32'h12A);
    seq.self_test(1'b0, 8'h2A);
    repeat (2) @(negedge mclk);
    check("sub hidden", {23'h0, disp_sub_en, disp_sub}, 32'h0);
  endtask : sc_selftest
  task automatic sc_irq();
    ahb(OFS_IRQ_STAT, 1'b1, 32'h7);
    ahb(OFS_IRQ_MASK, 1'b1, 32'h0);
    get_rec(8'h02, 1'b0, 4'h0);
    check("masked irq", {31'h0, irq}, 32'h0);
    ahb(OFS_IRQ_STAT, 1'b0, 32'h0);
    check("irq stat", rd, 32'h3);
    ahb(OFS_IRQ_MASK, 1'b1, 32'h7);
    repeat (2) @(negedge mclk);
    check("irq on", {31'h0, irq}, 32'h1);
    ahb(OFS_IRQ_STAT, 1'b1, 32'h3);
    repeat (2) @(negedge mclk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    ahb(8'h40, 1'b0, 32'h0);
    check("unmapped", {rd[30:0], hresp}, 32'h0);
  endtask : sc_irq
  task automatic sc_regs();
    ahb(OFS_RESULT, 1'b0, 32'h0);
    check("result reg", rd, 32'hA5C30002);
    ahb(OFS_COUNT, 1'b0, 32'h0);
    check("count reg", rd, {14'h0, ST_DONE, 16'(recs)});
    ahb(OFS_WORD, 1'b0, 32'h0);
    check("word before clear", rd, 32'h2);
    ahb(OFS_CTRL, 1'b1, 32'h1);
    ahb(OFS_WORD, 1'b0, 32'h0);
    check("word cleared", rd, 32'h0);
    repeat (2) @(negedge mclk);
    check("disp cleared", {16'h0, disp_word}, 32'h0);
  endtask : sc_regs
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    reset = 1'b1;
    {haddr, hwdata, htrans, hsize, hwrite} = 70'h0;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    sc_faults();
    sc_intr();
    sc_clean();
    sc_selftest();
    sc_irq();
    sc_regs();
    print_verdict();
  end
endmodule : measurement_error_status_word_test
